// >>> logic/lclfr_cfg.svh
// Register map, field positions and timing constants of the lock fault block
`ifndef LCLFR_CFG_SVH
`define LCLFR_CFG_SVH
`define LCL_ADDR_W 8
`define LCL_OFS_CFG 8'h00
`define LCL_OFS_CTRL 8'h04
`define LCL_OFS_STS 8'h08
`define LCL_OFS_MSK 8'h0C
`define LCL_OFS_STATE 8'h10
`define LCL_MODE_MSB 18
`define LCL_MODE_LSB 15
`define LCL_DEG_MSB 14
`define LCL_DEG_LSB 11
`define LCL_RTY_MSB 10
`define LCL_RTY_LSB 7
`define LCL_LIM_MSB 3
`define LCL_LIM_LSB 0
`define LCL_CLR_BIT 8
`define LCL_CFG_RST 32'h00000000
`define LCL_MODE_LATCH_MAX 4'h3
`define LCL_MODE_RETRY_MAX 4'h7
`define LCL_MODE_REPORT 4'h8
`define LCL_CLK_MHZ 10
`define LCL_TICK_US 50
`define LCL_TICK_CYC (`LCL_TICK_US * `LCL_CLK_MHZ)
`define LCL_DEG_0 20'h00001
`define LCL_DEG_1 20'h00002
`define LCL_DEG_2 20'h00004
`define LCL_DEG_3 20'h0000A
`define LCL_DEG_4 20'h00014
`define LCL_DEG_5 20'h00032
`define LCL_DEG_6 20'h00064
`define LCL_DEG_7 20'h00096
`define LCL_DEG_8 20'h000C8
`define LCL_DEG_9 20'h001F4
`define LCL_DEG_A 20'h003E8
`define LCL_DEG_B 20'h005DC
`define LCL_DEG_C 20'h007D0
`define LCL_DEG_D 20'h00FA0
`define LCL_DEG_E 20'h02710
`define LCL_DEG_F 20'h04E20
`define LCL_RTY_HALF 20'h02710
`define LCL_RTY_SEC 20'h04E20
`endif

// >>> logic/lclfr_pkg.sv
// Types of the lock fault block
package lclfr_pkg;
	typedef enum logic [2:0] {
		ST_MON   = 3'b001,
		ST_FAULT = 3'b010,
		ST_RETRY = 3'b100
	} lclfr_fsm_e;
	typedef enum logic [2:0] {
		GATE_NORMAL = 3'h0,
		GATE_HIZ    = 3'h1,
		GATE_RECIRC = 3'h2,
		GATE_HSB    = 3'h3,
		GATE_LSB    = 3'h4
	} lclfr_gate_e;
	typedef struct packed {
		lclfr_fsm_e  fsm;
		lclfr_gate_e gate;
		logic        fault_n;
		logic        irq;
		logic [31:0] cfg;
		logic [3:0]  lim;
		logic [2:0]  sts;
		logic [2:0]  msk;
		logic [31:0] rdata;
		logic [15:0] pre;
		logic [19:0] deg;
		logic [19:0] rtm;
		logic [3:0]  rcnt;
		logic        qprev;
	} lclfr_state_s;
endpackage

// >>> logic/lclfr_top.sv
// Lock current limit fault response with register port and interrupt
`timescale 1ns/1ns
`include "lclfr_cfg.svh"

// Operation
// - Mode 0 latches a fault on a qualified event, pulls the fault pin low and tristates outputs.
// - Mode 1 latches a fault, pulls the fault pin low and sets the stage to recirculation.
// - Mode 2 latches a fault, pulls the fault pin low and brakes with all high sides on.
// - Mode 3 latches a fault, pulls the fault pin low and brakes with all low sides on.
// - Mode 4 tristates with the pin low, clears after the retry time, latches past the limit.
// - Mode 5 retries like mode 4 but recirculates, latching once retries reach the limit.
// - Mode 6 brakes high side with the pin low and auto clears per interval up to the limit.
// - Mode 7 brakes low side with the pin low, auto clears and latches past the limit.
// - Mode 8 only pulls the fault pin low and leaves the output stage untouched.
// - Modes 9 to F disable detection so no fault and no action follow.
// - The deglitch code picks one of sixteen times from 0.05 ms up to 1000 ms.
// - Mode sits in bits 18 to 15 and deglitch in bits 14 to 11, both writable, reset zero.
// - The retry code gives 500 ms for 1, 1 s for 2 and one more second per code up to 14 s.
module lclfr_top #(
	parameter logic [15:0] TICK_CYC = 16'(`LCL_TICK_CYC)
) (
	// Clock, reset, enable
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     en,
	// Register port
	input  wire logic [`LCL_ADDR_W-1:0]   addr,
	input  wire logic [31:0]              wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [31:0]              rdata,
	// Current limit comparator level
	input  wire logic                     over_limit,
	// Output stage, fault pin and interrupt
	output lclfr_pkg::lclfr_gate_e        gate_state,
	output logic                          fault_indicator_n,
	output logic                          irq
);

	lclfr_pkg::lclfr_state_s st_ff;
	lclfr_pkg::lclfr_state_s nxt_st;
	logic                    tick;
	logic                    qual;
	logic                    ev;
	logic [3:0]              mode;
	logic [3:0]              dsel;
	logic [3:0]              rsel;
	logic [2:0]              sts_clr;

	// Deglitch time in ticks per code
	function automatic logic [19:0] deg_ticks(input logic [3:0] c);
		case (c)
			4'h0: deg_ticks = `LCL_DEG_0;
			4'h1: deg_ticks = `LCL_DEG_1;
			4'h2: deg_ticks = `LCL_DEG_2;
			4'h3: deg_ticks = `LCL_DEG_3;
			4'h4: deg_ticks = `LCL_DEG_4;
			4'h5: deg_ticks = `LCL_DEG_5;
			4'h6: deg_ticks = `LCL_DEG_6;
			4'h7: deg_ticks = `LCL_DEG_7;
			4'h8: deg_ticks = `LCL_DEG_8;
			4'h9: deg_ticks = `LCL_DEG_9;
			4'hA: deg_ticks = `LCL_DEG_A;
			4'hB: deg_ticks = `LCL_DEG_B;
			4'hC: deg_ticks = `LCL_DEG_C;
			4'hD: deg_ticks = `LCL_DEG_D;
			4'hE: deg_ticks = `LCL_DEG_E;
			default: deg_ticks = `LCL_DEG_F;
		endcase
	endfunction

	// Retry interval in ticks, reserved code taken as shortest
	function automatic logic [19:0] rty_ticks(input logic [3:0] c);
		logic [19:0] secs;
		secs = {16'h0000, c} - 20'h00001;
		if (c <= 4'h1) begin
			rty_ticks = `LCL_RTY_HALF;
		end else begin
			rty_ticks = 20'(secs * `LCL_RTY_SEC);
		end
	endfunction

	// Output stage action of a fault mode
	function automatic lclfr_pkg::lclfr_gate_e act_gate(input logic [3:0] m);
		case (m[1:0])
			2'h0: act_gate = lclfr_pkg::GATE_HIZ;
			2'h1: act_gate = lclfr_pkg::GATE_RECIRC;
			2'h2: act_gate = lclfr_pkg::GATE_HSB;
			default: act_gate = lclfr_pkg::GATE_LSB;
		endcase
	endfunction

	// Configuration fields
	assign mode = st_ff.cfg[`LCL_MODE_MSB:`LCL_MODE_LSB];
	assign dsel = st_ff.cfg[`LCL_DEG_MSB:`LCL_DEG_LSB];
	assign rsel = st_ff.cfg[`LCL_RTY_MSB:`LCL_RTY_LSB];

	// Next state of the whole block
	always_comb begin
		nxt_st  = st_ff;
		tick    = 1'b0;
		qual    = 1'b0;
		ev      = 1'b0;
		sts_clr = 3'h0;
		if (en) begin
			// Free running tick prescaler
			if (st_ff.pre >= TICK_CYC - 16'h0001) begin
				nxt_st.pre = 16'h0000;
				tick       = 1'b1;
			end else begin
				nxt_st.pre = st_ff.pre + 16'h0001;
			end
			// Deglitch counter, restarts on any gap
			if (!over_limit) begin
				nxt_st.deg = 20'h00000;
			end else if (tick && st_ff.deg <= deg_ticks(dsel)) begin
				nxt_st.deg = st_ff.deg + 20'h00001;
			end
			qual         = over_limit && (st_ff.deg > deg_ticks(dsel));
			nxt_st.qprev = qual;
			ev           = qual && !st_ff.qprev && (mode <= `LCL_MODE_REPORT);
			// Register writes
			if (wr) begin
				if (addr == `LCL_OFS_CFG) begin
					nxt_st.cfg = wdata;
				end else if (addr == `LCL_OFS_CTRL) begin
					nxt_st.lim = wdata[`LCL_LIM_MSB:`LCL_LIM_LSB];
				end else if (addr == `LCL_OFS_STS) begin
					sts_clr = wdata[2:0];
				end else if (addr == `LCL_OFS_MSK) begin
					nxt_st.msk = wdata[2:0];
				end
			end
			nxt_st.sts = st_ff.sts & ~sts_clr;
			// Fault response sequencer
			case (st_ff.fsm)
				lclfr_pkg::ST_MON: begin
					if (ev) begin
						nxt_st.sts[0] = 1'b1;
						if (mode == `LCL_MODE_REPORT) begin
							nxt_st.fsm  = lclfr_pkg::ST_FAULT;
							nxt_st.gate = lclfr_pkg::GATE_NORMAL;
						end else if (mode <= `LCL_MODE_LATCH_MAX) begin
							nxt_st.fsm    = lclfr_pkg::ST_FAULT;
							nxt_st.gate   = act_gate(mode);
							nxt_st.sts[1] = 1'b1;
						end else if (st_ff.rcnt >= st_ff.lim) begin
							nxt_st.fsm    = lclfr_pkg::ST_FAULT;
							nxt_st.gate   = act_gate(mode);
							nxt_st.sts[1] = 1'b1;
						end else begin
							nxt_st.fsm  = lclfr_pkg::ST_RETRY;
							nxt_st.gate = act_gate(mode);
							nxt_st.rtm  = 20'h00000;
						end
					end
				end
				lclfr_pkg::ST_RETRY: begin
					if (tick) begin
						if (st_ff.rtm >= rty_ticks(rsel) - 20'h00001) begin
							nxt_st.fsm    = lclfr_pkg::ST_MON;
							nxt_st.gate   = lclfr_pkg::GATE_NORMAL;
							nxt_st.rcnt   = st_ff.rcnt + 4'h1;
							nxt_st.sts[2] = 1'b1;
						end else begin
							nxt_st.rtm = st_ff.rtm + 20'h00001;
						end
					end
				end
				lclfr_pkg::ST_FAULT: begin
					nxt_st.fsm = lclfr_pkg::ST_FAULT;
				end
				default: begin
					nxt_st.fsm  = lclfr_pkg::ST_MON;
					nxt_st.gate = lclfr_pkg::GATE_NORMAL;
				end
			endcase
			// Software fault clear
			if (wr && addr == `LCL_OFS_CTRL && wdata[`LCL_CLR_BIT]) begin
				nxt_st.fsm  = lclfr_pkg::ST_MON;
				nxt_st.gate = lclfr_pkg::GATE_NORMAL;
				nxt_st.rcnt = 4'h0;
			end
			nxt_st.fault_n = (nxt_st.fsm == lclfr_pkg::ST_MON);
			nxt_st.irq     = |(nxt_st.sts & nxt_st.msk);
			// Read data, valid the cycle after the strobe
			nxt_st.rdata = 32'h00000000;
			if (rd) begin
				if (addr == `LCL_OFS_CFG) begin
					nxt_st.rdata = st_ff.cfg;
				end else if (addr == `LCL_OFS_CTRL) begin
					nxt_st.rdata = {28'h0000000, st_ff.lim};
				end else if (addr == `LCL_OFS_STS) begin
					nxt_st.rdata = {29'h00000000, st_ff.sts};
				end else if (addr == `LCL_OFS_MSK) begin
					nxt_st.rdata = {29'h00000000, st_ff.msk};
				end else if (addr == `LCL_OFS_STATE) begin
					nxt_st.rdata = {19'h00000, qual, st_ff.rcnt, !st_ff.fault_n,
						st_ff.gate, 1'b0, st_ff.fsm};
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{
				fsm:     lclfr_pkg::ST_MON,
				gate:    lclfr_pkg::GATE_NORMAL,
				fault_n: 1'b1,
				cfg:     `LCL_CFG_RST,
				default: '0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign rdata             = st_ff.rdata;
	assign gate_state        = st_ff.gate;
	assign fault_indicator_n = st_ff.fault_n;
	assign irq               = st_ff.irq;

	// Checks, all on the block clock
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Latching modes act one cycle after the event
	AST_MODE0_HIZ: assert property (
		en && ev && mode == 4'h0 && st_ff.fsm == lclfr_pkg::ST_MON && !wr
		|=> st_ff.fsm == lclfr_pkg::ST_FAULT && !fault_indicator_n
		&& gate_state == lclfr_pkg::GATE_HIZ)
		else $error("mode 0 fault not latched");
	AST_MODE1_RECIRC: assert property (
		en && ev && mode == 4'h1 && st_ff.fsm == lclfr_pkg::ST_MON && !wr
		|=> gate_state == lclfr_pkg::GATE_RECIRC && !fault_indicator_n)
		else $error("mode 1 no recirculation");
	AST_MODE2_HSB: assert property (
		en && ev && mode == 4'h2 && st_ff.fsm == lclfr_pkg::ST_MON && !wr
		|=> gate_state == lclfr_pkg::GATE_HSB && !fault_indicator_n)
		else $error("mode 2 no high side brake");
	AST_MODE3_LSB: assert property (
		en && ev && mode == 4'h3 && st_ff.fsm == lclfr_pkg::ST_MON && !wr
		|=> gate_state == lclfr_pkg::GATE_LSB && !fault_indicator_n)
		else $error("mode 3 no low side brake");
	AST_LATCH_HOLD: assert property (
		st_ff.fsm == lclfr_pkg::ST_FAULT && !(wr && addr == `LCL_OFS_CTRL)
		|=> st_ff.fsm == lclfr_pkg::ST_FAULT && !fault_indicator_n)
		else $error("latched fault dropped");

	// Retrying modes
	AST_RETRY_ENTRY: assert property (
		en && ev && mode >= 4'h4 && mode <= 4'h7 && !wr
		&& st_ff.fsm == lclfr_pkg::ST_MON && st_ff.rcnt < st_ff.lim
		|=> st_ff.fsm == lclfr_pkg::ST_RETRY && !fault_indicator_n)
		else $error("retry not started");
	AST_RETRY_LATCH: assert property (
		en && ev && mode >= 4'h4 && mode <= 4'h7 && !wr
		&& st_ff.fsm == lclfr_pkg::ST_MON && st_ff.rcnt >= st_ff.lim
		|=> st_ff.fsm == lclfr_pkg::ST_FAULT && gate_state == act_gate($past(mode)))
		else $error("retry limit not latched");
	AST_RETRY_HOLD: assert property (
		st_ff.fsm == lclfr_pkg::ST_RETRY && !wr
		&& st_ff.rtm < rty_ticks(rsel) - 20'h00001
		|=> st_ff.fsm == lclfr_pkg::ST_RETRY && !fault_indicator_n && $stable(gate_state))
		else $error("retry state left early");
	AST_RETRY_CLEAR: assert property (
		st_ff.fsm == lclfr_pkg::ST_RETRY && en && tick && !wr
		&& st_ff.rtm >= rty_ticks(rsel) - 20'h00001
		|=> fault_indicator_n && st_ff.rcnt == $past(st_ff.rcnt) + 4'h1)
		else $error("auto clear missed");

	// Report only and disabled modes
	AST_REPORT_ONLY: assert property (
		en && ev && mode == `LCL_MODE_REPORT && !wr && st_ff.fsm == lclfr_pkg::ST_MON
		|=> !fault_indicator_n && gate_state == lclfr_pkg::GATE_NORMAL)
		else $error("report mode acted");
	AST_DISABLED: assert property (
		en && mode > `LCL_MODE_REPORT && st_ff.fsm == lclfr_pkg::ST_MON
		|=> st_ff.fsm == lclfr_pkg::ST_MON && fault_indicator_n)
		else $error("disabled mode faulted");

	// Filter and configuration
	AST_DEG_COUNT: assert property (
		en && over_limit && tick && st_ff.deg <= deg_ticks(dsel)
		|=> st_ff.deg == $past(st_ff.deg) + 20'h00001)
		else $error("deglitch count stalled");
	AST_DEGLITCH_GAP: assert property (
		en && !over_limit
		|=> !qual && st_ff.deg == 20'h00000)
		else $error("deglitch not restarted");
	AST_CFG_WRITE: assert property (
		en && wr && addr == `LCL_OFS_CFG
		|=> mode == $past(wdata[`LCL_MODE_MSB:`LCL_MODE_LSB])
		&& dsel == $past(wdata[`LCL_DEG_MSB:`LCL_DEG_LSB]))
		else $error("configuration write lost");
	AST_SW_CLEAR: assert property (
		en && wr && addr == `LCL_OFS_CTRL && wdata[`LCL_CLR_BIT]
		|=> st_ff.rcnt == 4'h0 && fault_indicator_n)
		else $error("clear ignored");

	// Main scenarios reached
	COV_LATCH: cover property (st_ff.fsm == lclfr_pkg::ST_FAULT && mode == 4'h0);
	COV_RETRY_DONE: cover property (st_ff.fsm == lclfr_pkg::ST_RETRY
		##1 st_ff.fsm == lclfr_pkg::ST_MON);
	COV_IRQ: cover property (irq && st_ff.sts[2]);
	COV_REPORT: cover property (st_ff.fsm == lclfr_pkg::ST_FAULT
		&& gate_state == lclfr_pkg::GATE_NORMAL);
	COV_FROZEN: cover property (!en && over_limit);

endmodule // lclfr_top

// >>> tb/test_lclfr_top.sv
// Self-checking bench of the lock current fault response block
`timescale 1ns/1ns
module test_lclfr_top;
	typedef struct {string nm; logic [31:0] exp;} lclfr_note_s;
	logic                   clk, rst_n, en, wr, rd, over_limit;
	logic                   irq, fault_indicator_n, pin_req, rd_seen;
	logic [7:0]             addr;
	logic [31:0]            wdata, rdata, v, seed;
	lclfr_pkg::lclfr_gate_e gate_state;
	lclfr_note_s            q[$];
	int                     n_errors, compares;
	int                     deg_ticks[12] = '{1, 2, 4, 10, 20, 50, 100, 150, 200,
		500, 1000, 1500};

	// Device under test with one tick per clock
	lclfr_top #(.TICK_CYC(16'h0001)) i_lclfr_top (
		.clk(clk), .rst_n(rst_n), .en(en), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .over_limit(over_limit), .gate_state(gate_state),
		.fault_indicator_n(fault_indicator_n), .irq(irq));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Random source
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Output stage request expected for a mode code
	function automatic lclfr_pkg::lclfr_gate_e gate_of(input int m);
		if (m >= 8) return lclfr_pkg::GATE_NORMAL;
		case (m % 4)
			0: return lclfr_pkg::GATE_HIZ;
			1: return lclfr_pkg::GATE_RECIRC;
			2: return lclfr_pkg::GATE_HSB;
			default: return lclfr_pkg::GATE_LSB;
		endcase
	endfunction

	// Compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Register write, one strobe cycle
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Register read, result noted for the watcher
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		q.push_back('{"rdata", e});
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask

	// Pin snapshot request, result noted for the watcher
	task automatic pins(input lclfr_pkg::lclfr_gate_e g, input logic f, input logic i);
		q.push_back('{"pins", {27'h0, i, f, g}});
		@(posedge clk);
		pin_req <= 1'b1;
		@(posedge clk);
		pin_req <= 1'b0;
	endtask

	// Over limit level held for h cycles, then settle
	task automatic hold(input int h);
		@(posedge clk);
		over_limit <= 1'b1;
		repeat (h) @(posedge clk);
		over_limit <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic print_verdict;
		$display("Errors %0d, compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watcher: takes the oldest note when a result is due
	always @(negedge clk) begin
		lclfr_note_s n;
		if (rd_seen) begin
			n = q.pop_front();
			check(n.nm, rdata, n.exp);
		end
		if (pin_req) begin
			n = q.pop_front();
			check(n.nm, {27'h0, irq, fault_indicator_n, gate_state}, n.exp);
		end
		rd_seen = rd;
	end

	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		print_verdict();
	end

	// Main sequence
	initial begin
		seed = 32'h235A7A3F;
		{en, wr, rd, over_limit, pin_req, rd_seen} = 6'h20;
		addr = 8'h00;
		wdata = 32'h0;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, read back, unmapped place
		rd_reg(8'h00, 32'h0);
		rd_reg(8'h0C, 32'h0);
		seed = xs(seed);
		v = {seed[31:19], 4'h9, seed[14:0]};
		wr_reg(8'h00, v);
		rd_reg(8'h00, v);
		wr_reg(8'h44, seed);
		rd_reg(8'h44, 32'h0);
		wr_reg(8'h0C, 32'h7);
		rd_reg(8'h0C, 32'h7);
		// Every mode code, retry limit zero, mask open
		for (int m = 0; m < 16; m++) begin
			wr_reg(8'h00, 32'(m) << 15);
			wr_reg(8'h04, 32'h100);
			wr_reg(8'h08, 32'h7);
			hold(5);
			pins(gate_of(m), m > 8, m < 9);
			rd_reg(8'h08, m < 8 ? 32'h3 : (m == 8 ? 32'h1 : 32'h0));
			wr_reg(8'h04, 32'h100);
			wr_reg(8'h08, 32'h7);
			pins(lclfr_pkg::GATE_NORMAL, 1'b1, 1'b0);
		end
		// Enable low freezes the filter, a second level of the same length faults once enabled
		wr_reg(8'h00, 32'h0);
		@(posedge clk);
		en <= 1'b0;
		hold(5);
		pins(lclfr_pkg::GATE_NORMAL, 1'b1, 1'b0);
		en <= 1'b1;
		hold(5);
		pins(lclfr_pkg::GATE_HIZ, 1'b0, 1'b1);
		wr_reg(8'h04, 32'h100);
		wr_reg(8'h08, 32'h7);
		// Deglitch codes 0 to 11 in report mode, short hold from code 1, full hold for every code
		for (int c = 0; c < 12; c++) begin
			wr_reg(8'h00, (32'h8 << 15) | (32'(c) << 11));
			if (c > 0) begin
				hold(deg_ticks[c] - 1);
				pins(lclfr_pkg::GATE_NORMAL, 1'b1, 1'b0);
			end
			hold(deg_ticks[c] + 4);
			pins(lclfr_pkg::GATE_NORMAL, 1'b0, 1'b1);
			wr_reg(8'h04, 32'h100);
			wr_reg(8'h08, 32'h7);
		end
		// Retry modes, limit one, 500 ms interval, mask closed
		wr_reg(8'h0C, 32'h0);
		for (int m = 4; m < 8; m++) begin
			wr_reg(8'h00, (32'(m) << 15) | (32'h1 << 7));
			wr_reg(8'h04, 32'h101);
			hold(5);
			wr_reg(8'h08, 32'h7);
			pins(gate_of(m), 1'b0, 1'b0);
			repeat (9950) @(posedge clk);
			pins(gate_of(m), 1'b0, 1'b0);
			repeat (60) @(posedge clk);
			pins(lclfr_pkg::GATE_NORMAL, 1'b1, 1'b0);
			rd_reg(8'h08, 32'h4);
			hold(5);
			rd_reg(8'h10, {19'h0, 1'b0, 4'h1, 1'b1, gate_of(m), 1'b0, 3'b010});
		end
		// Reset in mid run drops the latched fault and the retry count
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		pins(lclfr_pkg::GATE_NORMAL, 1'b1, 1'b0);
		rd_reg(8'h10, 32'h1);
		rd_reg(8'h00, 32'h0);
		print_verdict();
	end
endmodule // test_lclfr_top
